// file: design/crx_pkg.sv
// Constants and types shared by the conditional-return execution unit.
package crx_pkg;
    // Instruction word layout.
    localparam int unsigned WORD_W = 32;
    localparam int unsigned OP_HI_LSB = 26;
    localparam int unsigned OP_HI_W = 6;
    localparam logic [5:0] OP_HI_RET = 6'h1e;
    localparam int unsigned KIND_LSB = 21;
    localparam int unsigned KIND_W = 5;
    localparam logic [4:0] KIND_IRQ_RET = 5'h00;
    localparam logic [4:0] KIND_SUB_RET = 5'h04;
    localparam int unsigned COND_LSB = 16;
    localparam int unsigned COND_W = 5;
    localparam int unsigned LOW_W = 16;
    localparam logic [15:0] LOW_ZERO = 16'h0000;
    // Number of supported condition codes; higher codes are refused.
    localparam logic [4:0] NUM_COND = 5'h14;

    // Status word bit positions.
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_UF = 4;
    localparam int unsigned FLAG_LV = 5;
    localparam int unsigned FLAG_LUF = 6;
    localparam int unsigned GIE_BIT = 13;
    localparam logic [31:0] GIE_MASK = 32'h0000_2000;

    // Interrupt lines gated by the global enable.
    localparam int unsigned NUM_IRQ = 10;

    // Timing of a taken return, in clock cycles.
    localparam int unsigned TAKEN_CYCLES = 4;
    localparam logic [1:0] CNT_FIRST = 2'h1;
    localparam logic [1:0] CNT_LAST = 2'(TAKEN_CYCLES - 1);
    localparam logic [31:0] SP_STEP = 32'h0000_0001;

    // Condition codes carried in the condition field.
    typedef enum logic [4:0] {
        CC_ALWAYS = 5'b00000, CC_LO = 5'b00001, CC_LS = 5'b00010, CC_HI = 5'b00011,
        CC_HS = 5'b00100, CC_EQ = 5'b00101, CC_NE = 5'b00110, CC_LT = 5'b00111,
        CC_LE = 5'b01000, CC_GT = 5'b01001, CC_GE = 5'b01010, CC_NV = 5'b01011,
        CC_V = 5'b01100, CC_NUF = 5'b01101, CC_UF = 5'b01110, CC_NLV = 5'b01111,
        CC_LV = 5'b10000, CC_NLUF = 5'b10001, CC_LUF = 5'b10010, CC_ZUF = 5'b10011
    } crx_cond_e;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POP = 2'b01
    } crx_state_e;
endpackage : crx_pkg

// file: design/crx_exec.sv
// Execution unit for the conditional interrupt-return and subroutine-return instructions.
`timescale 1ns/1ns
module crx_exec (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction offered by the fetch stage.
    input wire logic inst_valid,
    input wire logic [31:0] inst_word,
    // Core state seen at issue.
    input wire logic [31:0] status_word,
    input wire logic [31:0] stack_top_word,
    input wire logic [31:0] stack_ptr,
    // Interrupt controller side.
    input wire logic gie_clear,
    input wire logic [crx_pkg::NUM_IRQ-1:0] irq_request,
    input wire logic [crx_pkg::NUM_IRQ-1:0] irq_enable,
    // Handshake toward the fetch stage.
    output logic ready_ff,
    output logic busy_ff,
    output logic skip_ff,
    output logic cond_bad_ff,
    // Program counter and stack pointer updates.
    output logic pc_load_ff,
    output logic [31:0] pc_value_ff,
    output logic sp_dec_ff,
    output logic [31:0] sp_value_ff,
    // Status word write-back and interrupt gating.
    output logic status_wr_ff,
    output logic [31:0] status_wr_data_ff,
    output logic global_irq_enable_ff,
    output logic [crx_pkg::NUM_IRQ-1:0] irq_takeable_ff
);
    // Sequencer state and captured operands.
    crx_pkg::crx_state_e state_ff, nxt_state;
    logic [1:0] cnt_ff; // Cycle count inside a taken return.
    logic is_int_ff; // The running return is an interrupt return.
    logic [31:0] top_ff; // Stack top captured at issue.
    logic [31:0] sp_ff; // Stack pointer captured at issue.
    logic [31:0] st_ff; // Status word captured at issue.

    // Field extraction.
    wire [5:0] op_hi = inst_word[crx_pkg::OP_HI_LSB +: crx_pkg::OP_HI_W];
    wire [4:0] kind = inst_word[crx_pkg::KIND_LSB +: crx_pkg::KIND_W];
    wire [4:0] cond = inst_word[crx_pkg::COND_LSB +: crx_pkg::COND_W];
    wire [15:0] low = inst_word[crx_pkg::LOW_W-1:0];

    // A word shaped like a return, before the condition code is vetted.
    wire ret_shape = inst_valid && (op_hi == crx_pkg::OP_HI_RET) && (low == crx_pkg::LOW_ZERO)
        && ((kind == crx_pkg::KIND_IRQ_RET) || (kind == crx_pkg::KIND_SUB_RET));
    wire cond_ok = (cond < crx_pkg::NUM_COND);
    wire is_reti = ret_shape && cond_ok && (kind == crx_pkg::KIND_IRQ_RET);
    wire is_rets = ret_shape && cond_ok && (kind == crx_pkg::KIND_SUB_RET);
    wire idle = (state_ff == crx_pkg::ST_IDLE);
    wire accept = idle && (is_reti || is_rets);
    wire refuse = idle && ret_shape && !cond_ok;

    // Flags used by the condition test; the overflow-mode bit is never looked at.
    wire f_c = status_word[crx_pkg::FLAG_C];
    wire f_v = status_word[crx_pkg::FLAG_V];
    wire f_z = status_word[crx_pkg::FLAG_Z];
    wire f_n = status_word[crx_pkg::FLAG_N];
    wire f_uf = status_word[crx_pkg::FLAG_UF];
    wire f_lv = status_word[crx_pkg::FLAG_LV];
    wire f_luf = status_word[crx_pkg::FLAG_LUF];

    // Condition evaluation against the current flags.
    function automatic logic cond_eval(input logic [4:0] code, input logic c, input logic v,
                                       input logic z, input logic n, input logic uf,
                                       input logic lv, input logic luf);
        logic r;
        r = 1'b0;
        case (crx_pkg::crx_cond_e'(code))
            crx_pkg::CC_ALWAYS: r = 1'b1;
            crx_pkg::CC_LO: r = c;
            crx_pkg::CC_LS: r = c | z;
            crx_pkg::CC_HI: r = ~c & ~z;
            crx_pkg::CC_HS: r = ~c;
            crx_pkg::CC_EQ: r = z;
            crx_pkg::CC_NE: r = ~z;
            crx_pkg::CC_LT: r = n;
            crx_pkg::CC_LE: r = n | z;
            crx_pkg::CC_GT: r = ~n & ~z;
            crx_pkg::CC_GE: r = ~n;
            crx_pkg::CC_NV: r = ~v;
            crx_pkg::CC_V: r = v;
            crx_pkg::CC_NUF: r = ~uf;
            crx_pkg::CC_UF: r = uf;
            crx_pkg::CC_NLV: r = ~lv;
            crx_pkg::CC_LV: r = lv;
            crx_pkg::CC_NLUF: r = ~luf;
            crx_pkg::CC_LUF: r = luf;
            crx_pkg::CC_ZUF: r = z | uf;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_eval

    wire cond_true = cond_eval(cond, f_c, f_v, f_z, f_n, f_uf, f_lv, f_luf);
    wire start = accept && cond_true;
    wire finish = (state_ff == crx_pkg::ST_POP) && (cnt_ff == crx_pkg::CNT_LAST);

    // Next-state decode: a taken return holds the unit for the full pop sequence.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            crx_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_state = crx_pkg::ST_POP;
                end
            end
            crx_pkg::ST_POP: begin
                if (finish) begin
                    nxt_state = crx_pkg::ST_IDLE;
                end
            end
            default: nxt_state = crx_pkg::ST_IDLE;
        endcase
    end

    // The global enable is set on a taken interrupt return; the set wins over a clear.
    wire nxt_gie = (finish && is_int_ff) ? 1'b1 : (gie_clear ? 1'b0 : global_irq_enable_ff);
    wire [31:0] nxt_sp = sp_ff - crx_pkg::SP_STEP;
    wire [1:0] nxt_cnt = (state_ff == crx_pkg::ST_POP) ? cnt_ff + 2'h1 : crx_pkg::CNT_FIRST;

    // Sequencer registers.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= crx_pkg::ST_IDLE;
            cnt_ff <= 2'h0;
            ready_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            // Ready only once reset is over, so nothing issues into a cold unit.
            ready_ff <= (nxt_state == crx_pkg::ST_IDLE);
            busy_ff <= (nxt_state == crx_pkg::ST_POP);
        end
    end

    // Operands are captured at issue so that later flag changes cannot alter the return.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            is_int_ff <= 1'b0;
            top_ff <= 32'h0000_0000;
            sp_ff <= 32'h0000_0000;
            st_ff <= 32'h0000_0000;
        end else if (start) begin
            is_int_ff <= is_reti;
            top_ff <= stack_top_word;
            sp_ff <= stack_ptr;
            st_ff <= status_word;
        end
    end

    // Result pulses at the end of the fourth cycle; a false condition just steps on.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_ff <= 1'b0;
            cond_bad_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_value_ff <= 32'h0000_0000;
            sp_dec_ff <= 1'b0;
            sp_value_ff <= 32'h0000_0000;
        end else begin
            skip_ff <= accept && !cond_true;
            cond_bad_ff <= refuse;
            pc_load_ff <= finish;
            sp_dec_ff <= finish;
            if (finish) begin
                pc_value_ff <= top_ff;
                sp_value_ff <= nxt_sp;
            end
        end
    end

    // Status write-back carries the captured flags untouched, with only the enable forced.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_wr_ff <= 1'b0;
            status_wr_data_ff <= 32'h0000_0000;
            global_irq_enable_ff <= 1'b0;
        end else begin
            status_wr_ff <= finish && is_int_ff;
            if (finish && is_int_ff) begin
                status_wr_data_ff <= st_ff | crx_pkg::GIE_MASK;
            end
            global_irq_enable_ff <= nxt_gie;
        end
    end

    // Per-line gating: a request passes only with its own enable and the global enable.
    genvar gi;
    generate
        for (gi = 0; gi < crx_pkg::NUM_IRQ; gi++) begin : g_irq
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_takeable_ff[gi] <= 1'b0;
                end else begin
                    irq_takeable_ff[gi] <= irq_request[gi] & irq_enable[gi]
                        & global_irq_enable_ff;
                end
            end
        end
    endgenerate

    // Checks on the timing and effects of a return.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_taken_issue;
        accept && cond_true;
    endsequence

    sequence s_pop_wait;
        busy_ff [*3] ##1 !busy_ff;
    endsequence

    a_pc_load_time: assert property (s_taken_issue |-> ##4 (pc_load_ff
        && pc_value_ff == $past(stack_top_word, 4)))
        else $error("Taken return did not load the stack top after four cycles.");
    a_skip_not_taken: assert property ((accept && !cond_true) |=> (skip_ff && !busy_ff))
        else $error("Untaken return did not step on at once.");
    a_gie_set_int: assert property ((s_taken_issue and is_reti) |-> ##4
        (global_irq_enable_ff && status_wr_ff))
        else $error("Interrupt return did not set the global enable.");
    a_irq_gate_mask: assert property ((irq_takeable_ff & ~$past(irq_enable)) == '0
        && (!(|irq_takeable_ff) || $past(global_irq_enable_ff)))
        else $error("Interrupt passed without its enables.");
    a_cond_refused: assert property (cond_bad_ff |-> ($past(cond) >= crx_pkg::NUM_COND
        && !busy_ff))
        else $error("Condition code refusal out of place.");
    a_flags_kept: assert property (status_wr_ff |->
        (status_wr_data_ff == ($past(status_word, 4) | crx_pkg::GIE_MASK)))
        else $error("Return altered an arithmetic flag.");
    a_busy_span: assert property (s_taken_issue |=> s_pop_wait)
        else $error("Taken return did not occupy four cycles.");
    a_sp_step: assert property ((s_taken_issue and is_rets) |-> ##4 (sp_dec_ff
        && sp_value_ff == $past(stack_ptr, 4) - crx_pkg::SP_STEP && !status_wr_ff))
        else $error("Stack pointer not stepped down by one.");
endmodule : crx_exec

// file: sim/testbench.sv
// Self-checking testbench for the conditional-return execution unit.
`timescale 1ns/1ns
module testbench;
    logic sys_clk, rst_n, inst_valid, gie_clear;
    logic [31:0] inst_word, status_word, stack_top_word, stack_ptr;
    logic [crx_pkg::NUM_IRQ-1:0] irq_request, irq_enable, irq_takeable_ff;
    logic ready_ff, busy_ff, skip_ff, cond_bad_ff, pc_load_ff, sp_dec_ff, status_wr_ff;
    logic global_irq_enable_ff;
    logic [31:0] pc_value_ff, sp_value_ff, status_wr_data_ff;
    int n_mismatch = 0; // Mismatches seen so far.
    int checks = 0; // Comparisons made so far.
    // Taken flag per condition code when every status flag is zero.
    localparam logic [19:0] TAKEN_AT_ZERO = 20'h2ae59;

    crx_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .inst_valid(inst_valid),
        .inst_word(inst_word), .status_word(status_word), .stack_top_word(stack_top_word),
        .stack_ptr(stack_ptr), .gie_clear(gie_clear), .irq_request(irq_request),
        .irq_enable(irq_enable), .ready_ff(ready_ff), .busy_ff(busy_ff), .skip_ff(skip_ff),
        .cond_bad_ff(cond_bad_ff), .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff),
        .sp_dec_ff(sp_dec_ff), .sp_value_ff(sp_value_ff), .status_wr_ff(status_wr_ff),
        .status_wr_data_ff(status_wr_data_ff), .global_irq_enable_ff(global_irq_enable_ff),
        .irq_takeable_ff(irq_takeable_ff));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Compares one observed value with its expectation and counts the outcome.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // Builds a return-shaped instruction word.
    function automatic logic [31:0] mk(input logic [4:0] kind, input logic [4:0] cc);
        return {crx_pkg::OP_HI_RET, kind, cc, crx_pkg::LOW_ZERO};
    endfunction : mk

    // Issues one return and judges the whole answer; a taken one spans four cycles.
    task automatic run(input logic [31:0] word, input logic taken, input logic irq);
        logic [31:0] st;
        st = status_word;
        inst_valid = 1'b1;
        inst_word = word;
        @(negedge sys_clk);
        inst_valid = 1'b0;
        if (taken) begin
            chk("busy", busy_ff, 1);
            chk("ready", ready_ff, 0);
            repeat (3) @(negedge sys_clk);
            chk("pc_load", pc_load_ff, 1);
            chk("pc_value", pc_value_ff, stack_top_word);
            chk("sp_dec", sp_dec_ff, 1);
            chk("sp_value", sp_value_ff, stack_ptr - 32'h0000_0001);
            chk("ready_back", ready_ff, 1);
            chk("status_wr", status_wr_ff, irq);
            if (irq) begin
                chk("status_data", status_wr_data_ff, st | 32'h0000_2000);
                chk("gie", global_irq_enable_ff, 1);
            end
        end else begin
            chk("skip", skip_ff, 1);
            chk("no_load", pc_load_ff, 0);
            chk("no_busy", busy_ff, 0);
        end
        @(negedge sys_clk);
        chk("pulse_end", {skip_ff, pc_load_ff, sp_dec_ff, status_wr_ff}, 0);
    endtask : run

    // Taken interrupt return with every arithmetic flag set keeps those flags.
    task automatic t_irq_ret();
        status_word = 32'h0000_007f;
        stack_top_word = 32'h0000_0123;
        stack_ptr = 32'h0080_9830;
        run(mk(crx_pkg::KIND_IRQ_RET, crx_pkg::CC_ALWAYS), 1'b1, 1'b1);
        $display("test irq_ret done");
    endtask : t_irq_ret

    // Global enable opens only the individually enabled lines, and clearing closes them.
    task automatic t_gating();
        irq_request = 10'h3ff;
        irq_enable = 10'h155;
        repeat (2) @(negedge sys_clk);
        chk("takeable", irq_takeable_ff, 10'h155);
        gie_clear = 1'b1;
        @(negedge sys_clk);
        gie_clear = 1'b0;
        @(negedge sys_clk);
        chk("gie_off", global_irq_enable_ff, 0);
        chk("blocked", irq_takeable_ff, 0);
        $display("test gating done");
    endtask : t_gating

    // Taken subroutine return leaves the global enable alone.
    task automatic t_sub_ret();
        status_word = 32'h0000_0000;
        stack_top_word = 32'h0000_0456;
        stack_ptr = 32'h0080_983c;
        run(mk(crx_pkg::KIND_SUB_RET, crx_pkg::CC_GE), 1'b1, 1'b0);
        chk("gie_kept", global_irq_enable_ff, 0);
        run(mk(crx_pkg::KIND_IRQ_RET, crx_pkg::CC_EQ), 1'b0, 1'b0);
        chk("gie_untaken", global_irq_enable_ff, 0);
        $display("test sub_ret done");
    endtask : t_sub_ret

    // Every condition code, evaluated with all flags clear.
    task automatic t_codes();
        status_word = 32'h0000_0000;
        for (int i = 0; i < 20; i++) begin
            run(mk(crx_pkg::KIND_SUB_RET, 5'(i)), TAKEN_AT_ZERO[i], 1'b0);
        end
        $display("test codes done");
    endtask : t_codes

    // A code beyond the supported twenty is refused and the unit stays ready.
    task automatic t_bad_code();
        inst_valid = 1'b1;
        inst_word = mk(crx_pkg::KIND_IRQ_RET, 5'h14);
        @(negedge sys_clk);
        inst_valid = 1'b0;
        chk("cond_bad", cond_bad_ff, 1);
        chk("bad_ready", {ready_ff, pc_load_ff, skip_ff}, 3'h4);
        @(negedge sys_clk);
        chk("bad_end", cond_bad_ff, 0);
        $display("test bad_code done");
    endtask : t_bad_code

    // Cuts a hang short; the tests need far fewer cycles than this.
    initial begin
        #200000;
        n_mismatch++;
        results();
    end

    // Reset, then the scenarios in order.
    initial begin
        rst_n = 1'b0;
        inst_valid = 1'b0;
        inst_word = 32'h0000_0000;
        status_word = 32'h0000_0000;
        stack_top_word = 32'h0000_0000;
        stack_ptr = 32'h0000_0000;
        gie_clear = 1'b0;
        irq_request = 10'h000;
        irq_enable = 10'h000;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("ready_reset", {ready_ff, busy_ff}, 2'h2);
        t_irq_ret();
        t_gating();
        t_sub_ret();
        t_codes();
        t_bad_code();
        results();
    end
endmodule : testbench
